// ==== rtl/sap_pkg.sv ====
package sap_pkg;
    localparam int SAP_RES_W       = 16;
    localparam int SAP_HALF_W      = 8;
    localparam int SAP_CLK_MHZ     = 20;
    localparam int SAP_CLK_PS      = 50000;
    localparam int SAP_HOLD_MIN_NS = 40;
    localparam int SAP_HOLD_CYC    = ((SAP_HOLD_MIN_NS * 1000 + SAP_CLK_PS - 1) / SAP_CLK_PS) < 1 ? 1 :
                                     ((SAP_HOLD_MIN_NS * 1000 + SAP_CLK_PS - 1) / SAP_CLK_PS);
    localparam int SAP_CONV_CYC    = 64;
    localparam int SAP_FIFO_DEPTH  = 16;
    localparam logic [15:0] SAP_RESULT_RST = 16'h0000;

    typedef struct packed {
        logic chip_sel_n;
        logic read_conv;
        logic half_sel;
    } sap_ctrl_s;

    typedef struct packed {
        logic [15:0] bus_out;
        logic [15:0] bus_oe;
    } sap_bus_s;
endpackage

// ==== rtl/sap_fifo.sv ====
module sap_fifo
    import sap_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0]      cnt_reg, cnt_next;
    logic             push, pop, rdy_reg, rdy_next;

    assign in_ready  = rdy_reg;
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem[rd_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wr_next  = push ? AW'(wr_reg + 1'b1) : wr_reg;
        rd_next  = pop ? AW'(rd_reg + 1'b1) : rd_reg;
        cnt_next = (AW+1)'(cnt_reg + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0));
        rdy_next = (cnt_next != (AW+1)'(DEPTH));
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
            rdy_reg <= 1'b1;
        end else begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
            rdy_reg <= rdy_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end
endmodule

// ==== rtl/sap_adc_port.sv ====
// Functional notes
// [R1] conv_busy_n goes low at a conversion start and stays low until the result register is updated.
// [R2] half_sel low puts the upper result byte on data pins 7:0, high puts the lower byte there.
// [R3] chip select and read/convert are combined, so a chip select fall while read/convert is low starts a conversion.
// [R4] the data pins are released whenever chip select is high or read/convert is low.
// [R5] result_bit_msb is bit 15 and result_bit_lsb is bit 0 of the presented word.
// [R6] with chip select low a read/convert rise enables the outputs and a fall with busy high starts a conversion.
// [R7] a convert command while busy is low aborts the running conversion and restarts it.
// [R8] results appear in two's complement form.
// [R9] the host holds both inputs low for at least 40 ns to start a conversion.
// [R10] the last finished result is held for reading until the next conversion replaces it.
module sap_adc_port
    import sap_pkg::*;
#(
    parameter int CONV_CYC = SAP_CONV_CYC,
    parameter int DEPTH    = SAP_FIFO_DEPTH
) (
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire sap_ctrl_s            ctrl,
    input  wire logic                 sample_valid,
    output logic                      sample_ready,
    input  wire logic [SAP_RES_W-1:0] sample_data,
    output logic                      conv_busy_n,
    output sap_bus_s                  data_bus,
    output logic                      result_bit_msb,
    output logic                      result_bit_lsb
);
    typedef enum logic [1:0] {SAP_IDLE, SAP_ARM, SAP_CONV} sap_state_e;

    function automatic logic sap_fresh_low(input logic now_low, input logic was_low);
        return now_low && !was_low;
    endfunction

    sap_state_e         st_reg, st_next;
    logic [7:0]         cnt_reg, cnt_next;
    logic [15:0]        res_reg, res_next;
    logic               busy_n_reg, busy_n_next;
    logic               prev_low_reg;
    sap_bus_s           bus_reg, bus_next;
    logic               cmd_low, cmd_fresh, fifo_valid, fifo_pop;
    logic [15:0]        fifo_data;

    sap_fifo #(.WIDTH(SAP_RES_W), .DEPTH(DEPTH)) u_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .in_data   (sample_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    // [R3] combined convert level
    assign cmd_low   = !ctrl.chip_sel_n && !ctrl.read_conv;
    // [R6] fresh fall of combined level
    assign cmd_fresh = sap_fresh_low(cmd_low, prev_low_reg);
    // [R10] word consumed exactly when stored
    assign fifo_pop  = (st_reg == SAP_CONV) && (cnt_reg == 8'(CONV_CYC - 1)) && fifo_valid && !cmd_fresh;

    always_comb begin
        st_next     = st_reg;
        cnt_next    = cnt_reg;
        res_next    = res_reg;
        busy_n_next = busy_n_reg;
        case (st_reg)
            SAP_IDLE: begin
                // [R6] fresh low starts command
                if (cmd_fresh) begin
                    st_next  = SAP_ARM;
                    cnt_next = 8'h01;
                end
            end
            SAP_ARM: begin
                // [R9] minimum hold low
                if (!cmd_low) begin
                    st_next = SAP_IDLE;
                end else if (cnt_reg >= 8'(SAP_HOLD_CYC)) begin
                    st_next     = SAP_CONV;
                    cnt_next    = 8'h00;
                    // [R1] busy drops at start
                    busy_n_next = 1'b0;
                end else begin
                    cnt_next = 8'(cnt_reg + 1'b1);
                end
            end
            SAP_CONV: begin
                // [R7] new command aborts
                if (cmd_fresh) begin
                    cnt_next = 8'h00;
                end else if (cnt_reg == 8'(CONV_CYC - 1)) begin
                    if (fifo_valid) begin
                        // [R8] two's complement stored as is
                        res_next    = fifo_data;
                        busy_n_next = 1'b1;
                        st_next     = SAP_IDLE;
                    end
                end else begin
                    cnt_next = 8'(cnt_reg + 1'b1);
                end
            end
            default: begin
                st_next = SAP_IDLE;
            end
        endcase
    end

    always_comb begin
        bus_next = '0;
        // [R4] drive only when selected for read
        if (!ctrl.chip_sel_n && ctrl.read_conv) begin
            bus_next.bus_oe = 16'hffff;
            // [R2] byte select
            if (ctrl.half_sel) begin
                bus_next.bus_out = {res_next[15:8], res_next[7:0]};
            end else begin
                bus_next.bus_out = {res_next[15:8], res_next[15:8]};
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_reg         <= SAP_IDLE;
            cnt_reg        <= 8'h00;
            res_reg        <= SAP_RESULT_RST;
            busy_n_reg     <= 1'b1;
            prev_low_reg   <= 1'b0;
            bus_reg        <= '0;
            result_bit_msb <= 1'b0;
            result_bit_lsb <= 1'b0;
        end else begin
            st_reg         <= st_next;
            cnt_reg        <= cnt_next;
            // [R10] result held until replaced
            res_reg        <= res_next;
            busy_n_reg     <= busy_n_next;
            prev_low_reg   <= cmd_low;
            bus_reg        <= bus_next;
            // [R5] bit order
            result_bit_msb <= res_next[15];
            result_bit_lsb <= res_next[0];
        end
    end

    assign conv_busy_n = busy_n_reg;
    assign data_bus    = bus_reg;

    // [R3] fresh command seen while idle
    sequence seq_fresh_idle;
        (st_reg == SAP_IDLE) && cmd_fresh;
    endsequence

    // [R9] combined level kept low
    sequence seq_held_low;
        cmd_low [*2];
    endsequence

    // [R1] last conversion cycle, no restart
    sequence seq_conv_last;
        (st_reg == SAP_CONV) && (cnt_reg == 8'(CONV_CYC - 1)) && !cmd_fresh;
    endsequence

    // [R10] core word waiting
    sequence seq_word_there;
        fifo_valid;
    endsequence

    chk_busy_low_conv: assert property (@(posedge core_clk) disable iff (rst) // [R1]
        (st_reg == SAP_CONV) |-> !conv_busy_n)
        else $error("busy high during conversion");
    chk_bus_release: assert property (@(posedge core_clk) disable iff (rst) // [R4]
        (ctrl.chip_sel_n || !ctrl.read_conv) |=> (data_bus.bus_oe == 16'h0000))
        else $error("data pins driven while deselected");
    chk_bus_drive: assert property (@(posedge core_clk) disable iff (rst) // [R6]
        (!ctrl.chip_sel_n && ctrl.read_conv) |=> (data_bus.bus_oe == 16'hffff))
        else $error("data pins not driven on read");
    chk_upper_byte: assert property (@(posedge core_clk) disable iff (rst) // [R2]
        (!ctrl.chip_sel_n && ctrl.read_conv && !ctrl.half_sel) |=> (data_bus.bus_out[7:0] == res_reg[15:8]))
        else $error("upper byte wrong");
    chk_lower_byte: assert property (@(posedge core_clk) disable iff (rst) // [R2]
        (!ctrl.chip_sel_n && ctrl.read_conv && ctrl.half_sel) |=> (data_bus.bus_out[7:0] == res_reg[7:0]))
        else $error("lower byte wrong");
    chk_start_busy: assert property (@(posedge core_clk) disable iff (rst) // [R3]
        seq_fresh_idle ##1 seq_held_low |=> !conv_busy_n)
        else $error("conversion did not start");
    chk_abort_restart: assert property (@(posedge core_clk) disable iff (rst) // [R7]
        (st_reg == SAP_CONV && cmd_low && !prev_low_reg) |=> (cnt_reg == 8'h00 && !conv_busy_n))
        else $error("abort did not restart");
    chk_result_hold: assert property (@(posedge core_clk) disable iff (rst) // [R10]
        (st_reg != SAP_CONV) |=> $stable(res_reg))
        else $error("result changed outside conversion");
    chk_msb_pin: assert property (@(posedge core_clk) disable iff (rst) // [R5]
        1'b1 |=> (result_bit_msb == res_reg[15] && result_bit_lsb == res_reg[0]))
        else $error("msb or lsb pin wrong");
    chk_done_result: assert property (@(posedge core_clk) disable iff (rst) // [R8]
        fifo_pop |=> (res_reg == $past(fifo_data) && conv_busy_n))
        else $error("result not stored at end");

    chk_hold_first: assert property (@(posedge core_clk) disable iff (rst) // [R9]
        seq_fresh_idle |=> conv_busy_n)
        else $error("conversion started before hold time");
    chk_idle_busy: assert property (@(posedge core_clk) disable iff (rst) // [R1]
        (st_reg != SAP_CONV) |-> conv_busy_n)
        else $error("busy low outside conversion");
    chk_end_store: assert property (@(posedge core_clk) disable iff (rst) // [R1]
        seq_conv_last ##0 seq_word_there |=> (conv_busy_n && st_reg == SAP_IDLE))
        else $error("conversion did not end with a word");
    chk_busy_rise: assert property (@(posedge core_clk) disable iff (rst) // [R10]
        $rose(conv_busy_n) |-> $past(fifo_pop))
        else $error("busy rose without a stored word");
    chk_abort_keep: assert property (@(posedge core_clk) disable iff (rst) // [R7]
        (st_reg == SAP_CONV && cmd_fresh) |-> !fifo_pop)
        else $error("word consumed on abort");
    chk_upper_pins: assert property (@(posedge core_clk) disable iff (rst) // [R5]
        (!ctrl.chip_sel_n && ctrl.read_conv) |=> (data_bus.bus_out[15:8] == res_reg[15:8]))
        else $error("upper pins wrong");
    chk_released_zero: assert property (@(posedge core_clk) disable iff (rst) // [R4]
        (ctrl.chip_sel_n || !ctrl.read_conv) |=> (data_bus.bus_out == 16'h0000))
        else $error("released pins not cleared");
endmodule

// ==== test/sap_feeder.sv ====
module sap_feeder
    import sap_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire logic                 feed_en,
    input  wire logic                 sample_ready,
    output logic                      sample_valid,
    output logic      [SAP_RES_W-1:0] sample_data
);
    timeunit 1ns;
    timeprecision 1ns;
    // core result source, random stalls, word held until taken
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sample_valid <= 1'b0;
            sample_data  <= 16'h0000;
        end else if (!(sample_valid && !sample_ready)) begin
            sample_valid <= feed_en && ($urandom % 4 != 0);
            sample_data  <= 16'($urandom);
        end
    end
endmodule

// ==== test/sap_adc_port_bench.sv ====
module sap_adc_port_bench
    import sap_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic                 core_clk, rst, feed_en, sample_valid, sample_ready;
    logic                 conv_busy_n, result_bit_msb, result_bit_lsb;
    logic [SAP_RES_W-1:0] sample_data;
    sap_ctrl_s            ctrl;
    sap_bus_s             data_bus;
    logic [15:0]          q[$];
    logic [15:0]          exp_w;
    int                   error_cnt, total_checks;

    sap_adc_port #(.CONV_CYC(4), .DEPTH(16)) i_dut (.core_clk(core_clk), .rst(rst), .ctrl(ctrl),
        .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_data(sample_data),
        .conv_busy_n(conv_busy_n), .data_bus(data_bus), .result_bit_msb(result_bit_msb),
        .result_bit_lsb(result_bit_lsb));
    sap_feeder i_feed (.core_clk(core_clk), .rst(rst), .feed_en(feed_en), .sample_ready(sample_ready),
        .sample_valid(sample_valid), .sample_data(sample_data));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // reference queue of words accepted by the buffer
    always @(negedge core_clk) if (!rst && sample_valid && sample_ready) q.push_back(sample_data);

    task final_report();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask
    task wait_busy(input logic lvl);
        int n;
        for (n = 0; n < 400 && conv_busy_n !== lvl; n++) begin
            @(posedge core_clk);
            #1;
        end
        if (conv_busy_n !== lvl) begin
            $display("[ERR] busy wait expected %b seen %b", lvl, conv_busy_n);
            error_cnt++;
            final_report();
        end
    endtask
    task convert(input logic hs, input bit abort);
        @(posedge core_clk) ctrl <= '{1'b0, 1'b0, hs};
        wait_busy(1'b0);
        chk("oe_conv", 16'h0000, data_bus.bus_oe);
        if (abort) begin
            @(posedge core_clk) ctrl.read_conv <= 1'b1;
            @(posedge core_clk) ctrl.read_conv <= 1'b0;
            repeat (3) @(posedge core_clk);
            #1 chk("busy_abort", 16'h0000, 16'(conv_busy_n));
        end
        @(posedge core_clk) ctrl.read_conv <= 1'b1;
        wait_busy(1'b1);
        exp_w = q.pop_front();
        @(posedge core_clk);
        #1 chk("oe_read", 16'hffff, data_bus.bus_oe);
        chk("upper", exp_w[15:8], 16'(data_bus.bus_out[15:8]));
        chk("low_byte", hs ? exp_w[7:0] : exp_w[15:8], 16'(data_bus.bus_out[7:0]));
        chk("msb_lsb", {exp_w[15], exp_w[0]}, 16'({result_bit_msb, result_bit_lsb}));
    endtask

    initial begin
        int i;
        rst = 1'b1;
        feed_en = 1'b0;
        ctrl = '{1'b1, 1'b1, 1'b0};
        void'($urandom(65069));
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        #1 chk("busy_rst", 16'h0001, 16'(conv_busy_n));
        chk("oe_rst", 16'h0000, data_bus.bus_oe);
        @(posedge core_clk) feed_en <= 1'b1;
        repeat (40) @(posedge core_clk);
        for (i = 0; i < 20; i++) begin
            convert(1'($urandom), (i % 5) == 3);
        end
        ctrl.half_sel <= 1'b0;
        repeat (20) @(posedge core_clk);
        #1 chk("held", {exp_w[15:8], exp_w[15:8]}, data_bus.bus_out);
        @(posedge core_clk) ctrl.chip_sel_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1 chk("oe_cs_high", 16'h0000, data_bus.bus_oe);
        final_report();
    end
endmodule
